// >>> bench/rmrx_frame_source.sv
// Purpose: far-side stand-in that hands decoded 48-bit frames to the block
// Assumes: one call per frame, launched on the falling edge
// Notes: fields flip between frames so stale values never look fresh
`default_nettype none
module rmrx_frame_source (
    input wire logic i_clock,
    output logic o_frame_valid,
    output logic [10:0] o_frame_type,
    output logic [23:0] o_frame_msg,
    output logic o_type_check_ok,
    output logic o_msg_check_ok
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_frame_valid = 1'b0;
        o_frame_type = '0;
        o_frame_msg = '0;
        o_type_check_ok = 1'b0;
        o_msg_check_ok = 1'b0;
    end

    // one-cycle frame strobe, then a gap cycle with inverted fields
    task automatic send(input logic [10:0] t, input logic [23:0] m, input logic tok,
                        input logic mok);
        @(negedge i_clock);
        o_frame_valid = 1'b1;
        o_frame_type = t;
        o_frame_msg = m;
        o_type_check_ok = tok;
        o_msg_check_ok = mok;
        @(negedge i_clock);
        o_frame_valid = 1'b0;
        o_frame_type = ~t;
        o_frame_msg = ~m;
        o_type_check_ok = ~tok;
        o_msg_check_ok = ~mok;
    endtask
endmodule
`default_nettype wire

// >>> bench/rmrx_status_counters_tb_top.sv
// Purpose: self-checking bench of the remote monitor rx status and counters
// Assumes: byte register port with one-cycle read answer
// Notes: a small link model tracks lock and counter expectations
`include "rmrx_map.svh"
`default_nettype none
module rmrx_status_counters_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic rx_enable = 1'b0;
    logic [7:0] st_drv = 8'h00;
    logic inv_pulse = 1'b0;
    logic sec_tx_pulse = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic framer_locked;
    logic [7:0] rdata_m;
    logic frame_valid, type_ok, msg_ok;
    logic [10:0] frame_type;
    logic [23:0] frame_msg;
    int failures = 0;
    int cmp_count = 0;
    int sb[5] = '{0, 1, 2, 4, 5};
    logic lk = 1'b0;
    logic inv = 1'b0;
    int gd = 0;
    int bad = 0;
    logic [31:0] fc = '0;
    logic [15:0] te = '0, me = '0, lol = '0;
    logic [10:0] cap_t = '0;
    logic [23:0] cap_m = '0;
    logic [31:0] v;

    always #4 clock = ~clock;

    rmrx_status_counters dut (
        .i_clock(clock), .i_reset_n(reset_n), .i_rx_enable(rx_enable),
        .i_clock_locked(st_drv[0]), .i_bits_locked(st_drv[1]), .i_phase_locked(st_drv[2]),
        .i_high_tone_seen(st_drv[5]), .i_low_tone_seen(st_drv[4]),
        .i_inventory_validated(inv_pulse), .i_tx_security_idle(sec_tx_pulse),
        .i_frame_valid(frame_valid), .i_frame_type(frame_type), .i_frame_msg(frame_msg),
        .i_type_check_ok(type_ok), .i_msg_check_ok(msg_ok), .i_reg_addr(reg_addr),
        .i_reg_wr(reg_wr), .i_reg_wdata(reg_wdata), .i_reg_rd(reg_rd),
        .o_reg_rdata(reg_rdata), .o_framer_locked(framer_locked)
    );

    rmrx_frame_source src (
        .i_clock(clock), .o_frame_valid(frame_valid), .o_frame_type(frame_type),
        .o_frame_msg(frame_msg), .o_type_check_ok(type_ok), .o_msg_check_ok(msg_ok)
    );

    // second copy with bit locking merged into clock locking
    rmrx_status_counters #(.BITS_MERGED(1'b1)) dut_merged (
        .i_clock(clock), .i_reset_n(reset_n), .i_rx_enable(rx_enable),
        .i_clock_locked(st_drv[0]), .i_bits_locked(st_drv[1]), .i_phase_locked(st_drv[2]),
        .i_high_tone_seen(st_drv[5]), .i_low_tone_seen(st_drv[4]),
        .i_inventory_validated(inv_pulse), .i_tx_security_idle(sec_tx_pulse),
        .i_frame_valid(frame_valid), .i_frame_type(frame_type), .i_frame_msg(frame_msg),
        .i_type_check_ok(type_ok), .i_msg_check_ok(msg_ok), .i_reg_addr(reg_addr),
        .i_reg_wr(reg_wr), .i_reg_wdata(reg_wdata), .i_reg_rd(reg_rd),
        .o_reg_rdata(rdata_m), .o_framer_locked()
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
        end
    endtask

    // big-endian multi-byte read, one byte per access
    task automatic rd(input logic [7:0] addr, input int n, output logic [31:0] val);
        val = '0;
        for (int i = 0; i < n; i++) begin
            @(negedge clock);
            reg_rd = 1'b1;
            reg_addr = addr + 8'(i);
            @(negedge clock);
            reg_rd = 1'b0;
            @(negedge clock);
            val = {val[23:0], reg_rdata};
        end
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clock);
        reg_wr = 1'b1;
        reg_addr = addr;
        reg_wdata = data;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask

    task automatic frame(input logic [10:0] t, input logic [23:0] m, input logic tok,
                         input logic mok);
        src.send(t, m, tok, mok);
        if (lk) begin
            fc++;
            if (!tok) te++;
            else if (!mok) me++;
            if (tok && mok) begin
                bad = 0;
                cap_t = t;
                cap_m = m;
            end else begin
                bad++;
                if (bad == 6) begin
                    lk = 1'b0;
                    lol++;
                    gd = 0;
                end
            end
        end else begin
            gd = (tok && mok) ? gd + 1 : 0;
            if (gd == 2) begin
                lk = 1'b1;
                bad = 0;
            end
        end
    endtask

    task automatic check_counts();
        logic [7:0] exp_st;
        exp_st = {inv, 1'b0, st_drv[5:4], lk, st_drv[2:0]};
        rd(`RMRX_ADDR_LOL_HI, 2, v);
        chk(v, {16'h0, lol});
        rd(`RMRX_ADDR_FRAME_B3, 4, v);
        chk(v, fc);
        rd(`RMRX_ADDR_TERR_HI, 2, v);
        chk(v, {16'h0, te});
        rd(`RMRX_ADDR_MERR_HI, 2, v);
        chk(v, {16'h0, me});
        rd(`RMRX_ADDR_STATUS, 1, v);
        chk(v, {24'h0, exp_st});
        chk({24'h0, rdata_m}, {24'h0, exp_st | 8'h02});
        chk({31'h0, framer_locked}, {31'h0, lk});
    endtask

    task automatic caps();
        rd(`RMRX_ADDR_MSG_HI, 3, v);
        chk(v, {8'h0, cap_m});
        rd(`RMRX_ADDR_TYPE_HI, 2, v);
        chk(v, {21'h0, cap_t});
    endtask

    task automatic ev(input logic [10:0] t, input logic [23:0] m, input logic [7:0] e);
        frame(t, m, 1'b1, 1'b1);
        rd(`RMRX_ADDR_EVENT, 1, v);
        chk(v, {24'h0, e});
        rd(`RMRX_ADDR_EVENT, 1, v);
        chk(v, 32'h0);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        for (int i = 0; i < 100000; i++) begin
            @(posedge clock);
        end
        failures++;
        complete_run();
    end

    initial begin
        repeat (5) @(negedge clock);
        reset_n = 1'b1;
        rx_enable = 1'b1;
        for (int a = 8'hC0; a <= 8'hCF; a++) begin
            rd(8'(a), 1, v);
            chk(v, 32'h0);
        end
        rd(8'h10, 1, v);
        chk(v, 32'h0);
        foreach (sb[i]) begin
            st_drv = 8'h01 << sb[i];
            check_counts();
        end
        st_drv = 8'h37;
        @(negedge clock);
        inv_pulse = 1'b1;
        @(negedge clock);
        inv_pulse = 1'b0;
        inv = 1'b1;
        check_counts();
        // a bad frame between good ones must restart the lock search
        frame(11'h100, 24'h000001, 1'b1, 1'b1);
        frame(11'h100, 24'h000002, 1'b1, 1'b0);
        frame(11'h101, 24'h000003, 1'b1, 1'b1);
        check_counts();
        frame(11'h102, 24'h000004, 1'b1, 1'b1);
        check_counts();
        frame(11'h5A3, 24'hABCDEF, 1'b1, 1'b1);
        frame(11'h7FF, 24'h123456, 1'b0, 1'b0);
        frame(11'h0F0, 24'h654321, 1'b1, 1'b0);
        caps();
        check_counts();
        ev(`RMRX_TYPE_CONTROL, 24'h800000, 8'h01);
        ev(`RMRX_TYPE_CONTROL, 24'hC00000, 8'h02);
        ev(`RMRX_TYPE_CONTROL, 24'h400000, 8'h00);
        ev(`RMRX_TYPE_SEC_IDLE, 24'h000000, 8'h04);
        @(negedge clock);
        sec_tx_pulse = 1'b1;
        @(negedge clock);
        sec_tx_pulse = 1'b0;
        rd(`RMRX_ADDR_EVENT, 1, v);
        chk(v, 32'h08);
        // five bad frames then a good one keep lock; six in a row drop it
        for (int i = 0; i < 5; i++) frame(11'h011, 24'(i), i[0], 1'b0);
        frame(11'h012, 24'h000777, 1'b1, 1'b1);
        for (int i = 0; i < 6; i++) frame(11'h013, 24'(i), i[0], 1'b0);
        check_counts();
        frame(11'h014, 24'h000888, 1'b1, 1'b1);
        check_counts();
        wr(`RMRX_ADDR_STATUS, 8'h5A);
        wr(`RMRX_ADDR_FRAME_B3, `RMRX_CLEAR_CODE);
        check_counts();
        wr(`RMRX_ADDR_STATUS, `RMRX_CLEAR_CODE);
        fc = '0;
        te = '0;
        me = '0;
        lol = '0;
        check_counts();
        for (int i = 0; i < 302; i++) frame(11'h020, 24'(i), 1'b1, 1'b1);
        check_counts();
        caps();
        @(negedge clock);
        rx_enable = 1'b0;
        rd(`RMRX_ADDR_STATUS, 1, v);
        chk(v, 32'h0);
        rx_enable = 1'b1;
        {lk, inv, gd, bad, fc, te, me, lol} = '0;
        check_counts();
        complete_run();
    end
endmodule
`default_nettype wire

// >>> src/rmrx_framer_lock.sv
// Purpose: frame lock tracker fed by per-frame checksum results
// Assumes: one i_frame_valid pulse per received 48-bit frame
// Notes: o_lock_lost pulses one cycle as lock drops
`include "rmrx_map.svh"
`default_nettype none
module rmrx_framer_lock
    import rmrx_pkg::*;
#(
    parameter int GOOD_FRAMES = `RMRX_LOCK_GOOD_FRAMES,
    parameter int BAD_FRAMES = `RMRX_UNLOCK_BAD_FRAMES
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_enable,
    input wire logic i_frame_valid,
    input wire logic i_frame_good,
    output logic o_locked,
    output logic o_lock_lost
);
    rmrx_lock_state_t state_q, state_d;
    logic [2:0] run_q, run_d;
    logic lost_q, lost_d;
    logic [2:0] run_inc;

    assign run_inc = run_q + 3'h1;

    // consecutive good frames while searching, bad frames while locked
    always_comb begin
        state_d = state_q;
        run_d = run_q;
        lost_d = 1'b0;
        if (!i_enable) begin
            state_d = RMRX_SEARCH;
            run_d = 3'h0;
        end else if (i_frame_valid) begin
            case (state_q)
                RMRX_SEARCH: begin
                    if (!i_frame_good) begin
                        run_d = 3'h0;
                    end else if (run_inc == 3'(GOOD_FRAMES)) begin
                        state_d = RMRX_LOCKED;
                        run_d = 3'h0;
                    end else begin
                        run_d = run_inc;
                    end
                end
                RMRX_LOCKED: begin
                    if (i_frame_good) begin
                        run_d = 3'h0;
                    end else if (run_inc == 3'(BAD_FRAMES)) begin
                        state_d = RMRX_SEARCH;
                        run_d = 3'h0;
                        lost_d = 1'b1;
                    end else begin
                        run_d = run_inc;
                    end
                end
                default: begin
                    state_d = RMRX_SEARCH;
                    run_d = 3'h0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            state_q <= RMRX_SEARCH;
            run_q <= 3'h0;
            lost_q <= 1'b0;
        end else begin
            state_q <= state_d;
            run_q <= run_d;
            lost_q <= lost_d;
        end
    end

    assign o_locked = (state_q == RMRX_LOCKED);
    assign o_lock_lost = lost_q;
endmodule
`default_nettype wire

// >>> src/rmrx_map.svh
// Purpose: register map, field positions and timing figures of the remote monitor rx block
// Assumes: byte-wide management access, one register byte per address
// Notes: definitions only
`ifndef RMRX_MAP_SVH
`define RMRX_MAP_SVH

`define RMRX_ADDR_EVENT 8'hAF
`define RMRX_ADDR_STATUS 8'hC0
`define RMRX_ADDR_MSG_HI 8'hC1
`define RMRX_ADDR_MSG_MID 8'hC2
`define RMRX_ADDR_MSG_LO 8'hC3
`define RMRX_ADDR_TYPE_HI 8'hC4
`define RMRX_ADDR_TYPE_LO 8'hC5
`define RMRX_ADDR_LOL_HI 8'hC6
`define RMRX_ADDR_LOL_LO 8'hC7
`define RMRX_ADDR_FRAME_B3 8'hC8
`define RMRX_ADDR_FRAME_B0 8'hCB
`define RMRX_ADDR_TERR_HI 8'hCC
`define RMRX_ADDR_TERR_LO 8'hCD
`define RMRX_ADDR_MERR_HI 8'hCE
`define RMRX_ADDR_MERR_LO 8'hCF

`define RMRX_CLEAR_CODE 8'hA5
`define RMRX_TYPE_SEC_IDLE 11'h2AB
`define RMRX_TYPE_CONTROL 11'h2A0
`define RMRX_KIND_BIT 23
`define RMRX_NACK_BIT 22

`define RMRX_EVT_ACK 0
`define RMRX_EVT_NACK 1
`define RMRX_EVT_SEC_RX 2
`define RMRX_EVT_SEC_TX 3

`define RMRX_ST_CLOCK 0
`define RMRX_ST_BITS 1
`define RMRX_ST_PHASE 2
`define RMRX_ST_FRAME 3
`define RMRX_ST_LOW_TONE 4
`define RMRX_ST_HIGH_TONE 5
`define RMRX_ST_INVENTORY 7

`define RMRX_LOCK_GOOD_FRAMES 2
`define RMRX_UNLOCK_BAD_FRAMES 6
`define RMRX_MAX_OFFSET_PPM 100000

`endif

// >>> src/rmrx_pkg.sv
// Purpose: shared types of the remote monitor rx block
// Assumes: nothing beyond the map header
// Notes: constants live in rmrx_map.svh
`default_nettype none
package rmrx_pkg;
    typedef enum logic {RMRX_SEARCH, RMRX_LOCKED} rmrx_lock_state_t;
    typedef logic [7:0] rmrx_byte_t;
endpackage
`default_nettype wire

// >>> src/rmrx_status_counters.sv
// Purpose: rx status, debug capture, event latches and link counters of the remote monitor channel
// Assumes: frame strobe, checksum results and lock indications come from rx logic on i_clock
// Notes: register reads answer one cycle after i_reg_rd; reserved bits read zero
`include "rmrx_map.svh"
`default_nettype none
module rmrx_status_counters
    import rmrx_pkg::*;
#(
    parameter bit BITS_MERGED = 1'b0
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_rx_enable,
    input wire logic i_clock_locked,
    input wire logic i_bits_locked,
    input wire logic i_phase_locked,
    input wire logic i_high_tone_seen,
    input wire logic i_low_tone_seen,
    input wire logic i_inventory_validated,
    input wire logic i_tx_security_idle,
    input wire logic i_frame_valid,
    input wire logic [10:0] i_frame_type,
    input wire logic [23:0] i_frame_msg,
    input wire logic i_type_check_ok,
    input wire logic i_msg_check_ok,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    output logic o_framer_locked
);
    ////////////////////////////////////////////////////////////////////////////
    function automatic rmrx_byte_t byte_of(input logic [31:0] value, input logic [1:0] idx);
        byte_of = value[8*idx +: 8];
    endfunction

    logic lock_w;
    logic lock_lost_w;
    logic frame_good_w;
    logic [15:0] lol_cnt_q, lol_cnt_d;
    logic [31:0] frame_cnt_q, frame_cnt_d;
    logic [15:0] type_err_q, type_err_d;
    logic [15:0] msg_err_q, msg_err_d;
    logic [23:0] msg_cap_q;
    logic [10:0] type_cap_q;
    logic [3:0] event_q, event_d;
    logic [3:0] event_set_w;
    logic [7:0] status_q, status_d;
    logic inventory_q;
    logic [7:0] rdata_q, rdata_w;
    logic locked_q;

    ////////////////////////////////////////////////////////////////////////////
    // frame checks: a type failure hides the message result
    assign frame_good_w = i_type_check_ok && i_msg_check_ok;

    rmrx_framer_lock #(
        .GOOD_FRAMES(`RMRX_LOCK_GOOD_FRAMES),
        .BAD_FRAMES(`RMRX_UNLOCK_BAD_FRAMES)
    ) u_framer_lock (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_enable(i_rx_enable),
        .i_frame_valid(i_frame_valid),
        .i_frame_good(frame_good_w),
        .o_locked(lock_w),
        .o_lock_lost(lock_lost_w)
    );

    ////////////////////////////////////////////////////////////////////////////
    // register decode
    wire status_wr_w = i_reg_wr && (i_reg_addr == `RMRX_ADDR_STATUS);
    wire cnt_clr_w = (status_wr_w && (i_reg_wdata == `RMRX_CLEAR_CODE)) || !i_rx_enable;
    wire evt_rd_w = i_reg_rd && (i_reg_addr == `RMRX_ADDR_EVENT);
    wire frame_rd_w = (i_reg_addr >= `RMRX_ADDR_FRAME_B3) && (i_reg_addr <= `RMRX_ADDR_FRAME_B0);
    wire [1:0] frame_idx_w = 2'(`RMRX_ADDR_FRAME_B0 - i_reg_addr);

    wire counting_w = i_frame_valid && lock_w;
    wire type_fail_w = counting_w && !i_type_check_ok;
    wire msg_fail_w = counting_w && i_type_check_ok && !i_msg_check_ok;
    wire capture_w = counting_w && frame_good_w;
    wire sec_rx_w = i_frame_valid && i_type_check_ok && (i_frame_type == `RMRX_TYPE_SEC_IDLE);
    wire ctrl_kind_w = i_frame_valid && frame_good_w && (i_frame_type == `RMRX_TYPE_CONTROL)
        && i_frame_msg[`RMRX_KIND_BIT];

    assign event_set_w[`RMRX_EVT_SEC_TX] = i_tx_security_idle;
    assign event_set_w[`RMRX_EVT_SEC_RX] = sec_rx_w;
    assign event_set_w[`RMRX_EVT_NACK] = ctrl_kind_w && i_frame_msg[`RMRX_NACK_BIT];
    assign event_set_w[`RMRX_EVT_ACK] = ctrl_kind_w && !i_frame_msg[`RMRX_NACK_BIT];

    always_comb begin
        if (i_reg_addr == `RMRX_ADDR_EVENT) begin
            rdata_w = {4'h0, event_q};
        end else if (i_reg_addr == `RMRX_ADDR_STATUS) begin
            rdata_w = status_q;
        end else if (i_reg_addr == `RMRX_ADDR_MSG_HI) begin
            rdata_w = msg_cap_q[23:16];
        end else if (i_reg_addr == `RMRX_ADDR_MSG_MID) begin
            rdata_w = msg_cap_q[15:8];
        end else if (i_reg_addr == `RMRX_ADDR_MSG_LO) begin
            rdata_w = msg_cap_q[7:0];
        end else if (i_reg_addr == `RMRX_ADDR_TYPE_HI) begin
            rdata_w = {5'h00, type_cap_q[10:8]};
        end else if (i_reg_addr == `RMRX_ADDR_TYPE_LO) begin
            rdata_w = type_cap_q[7:0];
        end else if (i_reg_addr == `RMRX_ADDR_LOL_HI) begin
            rdata_w = lol_cnt_q[15:8];
        end else if (i_reg_addr == `RMRX_ADDR_LOL_LO) begin
            rdata_w = lol_cnt_q[7:0];
        end else if (frame_rd_w) begin
            rdata_w = byte_of(frame_cnt_q, frame_idx_w);
        end else if (i_reg_addr == `RMRX_ADDR_TERR_HI) begin
            rdata_w = byte_of({16'h0000, type_err_q}, 2'h1);
        end else if (i_reg_addr == `RMRX_ADDR_TERR_LO) begin
            rdata_w = byte_of({16'h0000, type_err_q}, 2'h0);
        end else if (i_reg_addr == `RMRX_ADDR_MERR_HI) begin
            rdata_w = byte_of({16'h0000, msg_err_q}, 2'h1);
        end else if (i_reg_addr == `RMRX_ADDR_MERR_LO) begin
            rdata_w = byte_of({16'h0000, msg_err_q}, 2'h0);
        end else begin
            rdata_w = 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // counters: clear has priority, all wrap naturally
    always_comb begin
        lol_cnt_d = lol_cnt_q;
        frame_cnt_d = frame_cnt_q;
        type_err_d = type_err_q;
        msg_err_d = msg_err_q;
        if (cnt_clr_w) begin
            lol_cnt_d = 16'h0000;
            frame_cnt_d = 32'h0000_0000;
            type_err_d = 16'h0000;
            msg_err_d = 16'h0000;
        end else begin
            if (lock_lost_w) begin
                lol_cnt_d = lol_cnt_q + 16'h0001;
            end
            if (counting_w) begin
                frame_cnt_d = frame_cnt_q + 32'h0000_0001;
            end
            if (type_fail_w) begin
                type_err_d = type_err_q + 16'h0001;
            end
            if (msg_fail_w) begin
                msg_err_d = msg_err_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            lol_cnt_q <= 16'h0000;
            frame_cnt_q <= 32'h0000_0000;
            type_err_q <= 16'h0000;
            msg_err_q <= 16'h0000;
        end else begin
            lol_cnt_q <= lol_cnt_d;
            frame_cnt_q <= frame_cnt_d;
            type_err_q <= type_err_d;
            msg_err_q <= msg_err_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // debug capture of the last good frame seen under lock
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            msg_cap_q <= 24'h00_0000;
            type_cap_q <= 11'h000;
        end else if (capture_w) begin
            msg_cap_q <= i_frame_msg;
            type_cap_q <= i_frame_type;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // clear-on-read event latches, a new event beats the read
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_event
            assign event_d[gi] = event_set_w[gi] || (event_q[gi] && !evt_rd_w);
        end
    endgenerate

    // one process owns all four latch bits
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            event_q <= 4'h0;
        end else begin
            event_q <= event_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status byte, all flags drop while the rx path is off
    always_comb begin
        status_d = 8'h00;
        if (i_rx_enable) begin
            status_d[`RMRX_ST_INVENTORY] = inventory_q;
            status_d[`RMRX_ST_HIGH_TONE] = i_high_tone_seen;
            status_d[`RMRX_ST_LOW_TONE] = i_low_tone_seen;
            status_d[`RMRX_ST_FRAME] = lock_w;
            status_d[`RMRX_ST_PHASE] = i_phase_locked;
            status_d[`RMRX_ST_BITS] = BITS_MERGED ? 1'b1 : i_bits_locked;
            status_d[`RMRX_ST_CLOCK] = i_clock_locked;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            inventory_q <= 1'b0;
            status_q <= 8'h00;
            rdata_q <= 8'h00;
            locked_q <= 1'b0;
        end else begin
            inventory_q <= i_rx_enable && (inventory_q || i_inventory_validated);
            status_q <= status_d;
            locked_q <= lock_w;
            if (i_reg_rd) begin
                rdata_q <= rdata_w;
            end
        end
    end

    assign o_reg_rdata = rdata_q;
    assign o_framer_locked = locked_q;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_reset_n);

    lol_count_a: assert property ((lock_lost_w && !cnt_clr_w) |=>
        (lol_cnt_q == $past(lol_cnt_q) + 16'h0001))
        else $error("loss-of-lock count did not step");
    counter_clear_a: assert property (cnt_clr_w |=>
        (frame_cnt_q == 32'h0000_0000 && type_err_q == 16'h0000 && msg_err_q == 16'h0000
        && lol_cnt_q == 16'h0000))
        else $error("counters not cleared");
    other_code_a: assert property ((status_wr_w && i_reg_wdata != `RMRX_CLEAR_CODE
        && i_rx_enable && !i_frame_valid && !lock_lost_w) |=>
        ($stable(frame_cnt_q) && $stable(type_err_q) && $stable(msg_err_q)))
        else $error("non-clear write changed counters");
    frame_step_a: assert property ((counting_w && !cnt_clr_w) |=>
        (frame_cnt_q == $past(frame_cnt_q) + 32'h0000_0001))
        else $error("frame count did not step");
    frame_halt_a: assert property ((!lock_w && !cnt_clr_w) |=> $stable(frame_cnt_q))
        else $error("frame count ran without lock");
    type_skip_a: assert property ((type_fail_w && !cnt_clr_w) |=>
        ($stable(msg_err_q) && type_err_q == $past(type_err_q) + 16'h0001))
        else $error("type failure misrouted");
    sec_rx_set_a: assert property (sec_rx_w |=> event_q[`RMRX_EVT_SEC_RX])
        else $error("security idle rx not latched");
    sticky_hold_a: assert property ((event_q[`RMRX_EVT_ACK] && !evt_rd_w) |=>
        event_q[`RMRX_EVT_ACK])
        else $error("event bit lost without read");
    read_clear_a: assert property ((evt_rd_w && !event_set_w[`RMRX_EVT_NACK]) |=>
        !event_q[`RMRX_EVT_NACK])
        else $error("event bit survived read");
    lock_status_a: assert property (lock_lost_w |=> !status_q[`RMRX_ST_FRAME])
        else $error("lock status stayed after loss");
    msg_capture_a: assert property (capture_w |=> (msg_cap_q == $past(i_frame_msg)))
        else $error("message not captured");
    type_upper_a: assert property ((i_reg_rd && i_reg_addr == `RMRX_ADDR_TYPE_HI) |=>
        (o_reg_rdata[7:3] == 5'h00))
        else $error("type high byte upper bits set");
    sec_tx_set_a: assert property (i_tx_security_idle |=> event_q[`RMRX_EVT_SEC_TX])
        else $error("security idle tx not latched");
    nack_set_a: assert property ((i_frame_valid && frame_good_w
        && i_frame_type == `RMRX_TYPE_CONTROL && i_frame_msg[`RMRX_KIND_BIT]
        && i_frame_msg[`RMRX_NACK_BIT]) |=> event_q[`RMRX_EVT_NACK])
        else $error("control nack not latched");
    ack_set_a: assert property ((i_frame_valid && frame_good_w
        && i_frame_type == `RMRX_TYPE_CONTROL && i_frame_msg[`RMRX_KIND_BIT]
        && !i_frame_msg[`RMRX_NACK_BIT]) |=> event_q[`RMRX_EVT_ACK])
        else $error("control ack not latched");
    inventory_hold_a: assert property ((status_q[`RMRX_ST_INVENTORY] && i_rx_enable) |=>
        status_q[`RMRX_ST_INVENTORY])
        else $error("inventory flag dropped");
    disable_flags_a: assert property (!i_rx_enable |=> (status_q == 8'h00))
        else $error("status flags set while rx off");
    bits_merged_a: assert property ((BITS_MERGED && i_rx_enable) |=> status_q[`RMRX_ST_BITS])
        else $error("merged bit lock flag low");
    type_capture_a: assert property (capture_w |=> (type_cap_q == $past(i_frame_type)))
        else $error("type not captured");
    capture_hold_a: assert property (!capture_w |=>
        ($stable(msg_cap_q) && $stable(type_cap_q)))
        else $error("capture changed without a locked good frame");
    msg_err_step_a: assert property ((msg_fail_w && !cnt_clr_w) |=>
        (msg_err_q == $past(msg_err_q) + 16'h0001))
        else $error("message error count did not step");

    lock_cover_c: cover property (!lock_w ##1 lock_w);
    lol_cover_c: cover property (lock_lost_w);
    clear_cover_c: cover property (cnt_clr_w && i_rx_enable && frame_cnt_q != 32'h0000_0000);
    ack_cover_c: cover property (event_set_w[`RMRX_EVT_ACK] && evt_rd_w);
    nack_cover_c: cover property (event_set_w[`RMRX_EVT_NACK]);
endmodule
`default_nettype wire
